// >>> logic/ipvu_pkg.sv
// Package for the interrupt priority vector unit: register map, fields, vectors
`default_nettype none
package ipvu_pkg;
  // Register indices and byte addresses (index times four)
  localparam logic [7:0]  IDX_TEST_CONTROL = 8'h15;
  localparam logic [7:0]  IDX_TEST_FORCE   = 8'h16;
  localparam logic [7:0]  IDX_PROMOTE_SEL  = 8'h1F;
  localparam logic [9:0]  ADDR_TEST_CONTROL = {IDX_TEST_CONTROL, 2'b00};
  localparam logic [9:0]  ADDR_TEST_FORCE   = {IDX_TEST_FORCE, 2'b00};
  localparam logic [9:0]  ADDR_PROMOTE_SEL  = {IDX_PROMOTE_SEL, 2'b00};
  localparam logic [9:0]  ADDR_STATUS       = 10'h080;
  // Field positions
  localparam int          TWE_BIT  = 4;
  localparam int          SEL_MSB  = 3;
  // Reset values
  localparam logic [3:0]  SEL_RESET     = 4'hF;
  localparam logic [7:0]  PROMOTE_RESET = 8'hF2;
  // Vector addresses
  localparam logic [15:0] VEC_SYS_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_OSC_MON   = 16'hFFFC;
  localparam logic [15:0] VEC_WATCHDOG  = 16'hFFFA;
  localparam logic [15:0] VEC_ILLEGAL   = 16'hFFF8;
  localparam logic [15:0] VEC_TRAP      = 16'hFFF6;
  localparam logic [15:0] VEC_NMI_PIN   = 16'hFFF4;
  localparam logic [15:0] VEC_LOW_PIN   = 16'hFFF2;
  localparam logic [7:0]  VEC_MASK_TOP  = 8'hF2;
  localparam logic [7:0]  VEC_PAGE      = 8'hFF;
  localparam int          MAX_SOURCES   = 122;
  // Reset request kinds
  typedef struct packed {
    logic system;
    logic osc_monitor;
    logic watchdog;
  } ipvu_reset_req_t;
  // Non-maskable and pin requests
  typedef struct packed {
    logic illegal_op;
    logic trap_or_debug;
    logic nmi_pin;
    logic low_pin;
  } ipvu_core_req_t;
  // Answer to the core's vector fetch
  typedef struct packed {
    logic        valid;
    logic [15:0] address;
  } ipvu_vector_t;
endpackage : ipvu_pkg
`default_nettype wire

// >>> logic/ipvu_top.sv
// Interrupt priority and vector unit with APB test registers
//
// Operation
// - Two to 122 low-mask interrupt vectors from page bottom up to FFF2.
// - One high-mask vector at FFF4 for the nonmaskable pin request.
// - Vector FFF6 serves both software trap and debug entry.
// - Vector FFF8 serves the illegal opcode exception.
// - Reset vectors FFFE system, FFFC oscillator monitor, FFFA watchdog.
// - Selected vector is driven onto address bus at vector fetch.
// - Pending output is raised while a valid request waits.
// - Core inhibit inputs suppress low- and high-level maskable requests.
// - Wake-up on valid interrupt, and on nonmaskable pin request even when high mask set.
// - Clock-free combinational request path for all maskable sources; pending_o, wake_o and vector_o are registered on clock_i.
// - Pin request states arrive as inputs from the external bus unit.
// - Test-write enable writable only in special mode with both masks set.
// - With test-write clear, test writes blocked, reads show live inputs.
// - With test-write set, decoder sees test registers, not real inputs.
// - Requests pending when test-write sets stay until overwritten.
// - Select field bits 3:0 is the vector low byte upper nibble.
// - Test reads only in special mode; zero in normal modes.
// - Test writes need special mode, test-write set and low mask set.
// - Each test bit forces one even vector offset, xE down to x0.
// - One test register per eight interrupts, all at one address.
// - With select F only bits 2:0 exist; bits 7:3 read zero.
// - Unimplemented test register: writes ignored, reads zero.
// - Invalid promotion value defaults to low pin vector FFF2.
// - Fetch with no request ever pending yields software trap vector.
//
// Added by the designer: register access over APB.
`default_nettype none
module ipvu_top
  import ipvu_pkg::*;
#(
  parameter int NUM_SOURCES = 122
) (
  // Clock and reset
  input  wire logic                   clock_i,
  input  wire logic                   rst_i,
  // APB slave
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [9:0]             paddr_i,
  input  wire logic [31:0]            pwdata_i,
  output logic      [31:0]            prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o,
  // Core state
  input  wire logic                   special_mode_i,
  input  wire logic                   low_mask_i,
  input  wire logic                   high_mask_i,
  input  wire logic                   low_inhibit_i,
  input  wire logic                   high_inhibit_i,
  // Requests
  input  wire logic [NUM_SOURCES-1:0] source_req_i,
  input  wire logic                   low_pin_req_n_i,
  input  wire logic                   nmi_pin_req_n_i,
  input  wire ipvu_core_req_t         core_req_i,
  input  wire ipvu_reset_req_t        reset_req_i,
  input  wire logic                   vector_fetch_i,
  // Answers
  output ipvu_vector_t                vector_o,
  output logic                        pending_o,
  output logic                        wake_o
);

  localparam int NUM_REGS = (NUM_SOURCES + 2 + 7) / 8;

  initial begin
    if (NUM_SOURCES < 2 || NUM_SOURCES > MAX_SOURCES) begin
      $error("NUM_SOURCES out of range");
    end
  end

  // Flat request vector: bit k is vector FF00 + 2k; bit 121 is FFF2, bit 122 FFF4
  localparam int FLAT_W = 128;

  logic [3:0]        test_select;
  logic              test_write_enable;
  logic [7:0]        promote_sel;
  logic [FLAT_W-1:0] test_force;
  logic [FLAT_W-1:0] live_flat;
  logic [FLAT_W-1:0] decode_flat;
  logic              ever_pending;
  logic [15:0]       last_vector;
  logic [15:0]       next_vector;
  logic              next_valid;
  logic              next_pending;

  // Live maskable requests in vector order
  always_comb begin
    live_flat = '0;
    for (int k = 0; k < NUM_SOURCES - 1; k++) begin
      live_flat[121 - (NUM_SOURCES - 1) + k] = source_req_i[k];
    end
    live_flat[121] = ~low_pin_req_n_i;
    live_flat[122] = ~nmi_pin_req_n_i;
  end

  // Register slot implemented for select F and the (NUM_SOURCES + 7) / 8 - 1 slots below it
  function automatic logic slot_present(input logic [3:0] sel);
    slot_present = (int'(sel) >= 15 - ((NUM_SOURCES + 7) / 8 - 1)) || (sel == 4'hF);
  endfunction : slot_present

  function automatic logic [7:0] slot_mask(input logic [3:0] sel);
    slot_mask = (sel == 4'hF) ? 8'h07 : 8'hFF;
  endfunction : slot_mask

  function automatic logic [7:0] slot_bits(input logic [FLAT_W-1:0] v, input logic [3:0] sel);
    slot_bits = v[{sel, 3'b000} +: 8];
  endfunction : slot_bits

  wire logic       apb_access   = psel_i & penable_i;
  wire logic       apb_wr       = apb_access & pwrite_i;
  wire logic       test_wr_ok   = special_mode_i & test_write_enable & low_mask_i;
  wire logic       slot_ok      = slot_present(test_select);

  // Test control register
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      test_select       <= SEL_RESET;
      test_write_enable <= 1'b0;
    end else if (apb_wr && paddr_i == ADDR_TEST_CONTROL) begin
      test_select <= pwdata_i[SEL_MSB:0];
      if (special_mode_i && low_mask_i && high_mask_i) begin
        test_write_enable <= pwdata_i[TWE_BIT];
      end
    end
  end

  // Promotion select, writable with low mask set
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      promote_sel <= PROMOTE_RESET;
    end else if (apb_wr && paddr_i == ADDR_PROMOTE_SEL && low_mask_i) begin
      promote_sel <= pwdata_i[7:0];
    end
  end

  // Test force storage; captures live state while test-write is off
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      test_force <= '0;
    end else if (!test_write_enable) begin
      test_force <= live_flat;
    end else if (apb_wr && paddr_i == ADDR_TEST_FORCE && test_wr_ok && slot_ok) begin
      for (int b = 0; b < 8; b++) begin
        if (slot_mask(test_select)[b]) begin
          test_force[{test_select, 3'b000} + 7'(b)] <= pwdata_i[b];
        end
      end
    end
  end

  // Decoder input source
  always_comb begin
    decode_flat = test_write_enable ? test_force : live_flat;
    decode_flat[FLAT_W-1:123] = '0;
  end

  // Priority decode
  always_comb begin
    logic [7:0] p;
    logic       p_ok;
    p = promote_sel;
    p_ok = 1'b0;
    next_vector = last_vector;
    next_valid  = 1'b1;
    // Default promotion to low pin vector
    if (p[0] || p > VEC_MASK_TOP || p < 8'(VEC_MASK_TOP - 8'(2 * (NUM_SOURCES - 1)))) begin
      p = VEC_MASK_TOP;
    end
    p_ok = decode_flat[p[7:1]] & ~low_mask_i & ~low_inhibit_i;
    if (reset_req_i.system) begin
      next_vector = VEC_SYS_RESET;
    end else if (reset_req_i.osc_monitor) begin
      next_vector = VEC_OSC_MON;
    end else if (reset_req_i.watchdog) begin
      next_vector = VEC_WATCHDOG;
    end else if (core_req_i.illegal_op) begin
      next_vector = VEC_ILLEGAL;
    end else if (core_req_i.trap_or_debug) begin
      next_vector = VEC_TRAP;
    end else if (decode_flat[122] && !high_mask_i && !high_inhibit_i) begin
      next_vector = VEC_NMI_PIN;
    end else if (p_ok) begin
      next_vector = {VEC_PAGE, p};
    end else if (!low_mask_i && !low_inhibit_i && |decode_flat[121:0]) begin
      for (int k = 0; k < 122; k++) begin
        if (decode_flat[k]) begin
          next_vector = {VEC_PAGE, 7'(k), 1'b0};
        end
      end
    end else if (!ever_pending) begin
      next_vector = VEC_TRAP;
    end
  end

  always_comb begin
    next_pending = (decode_flat[122] & ~high_mask_i & ~high_inhibit_i)
                 | (|decode_flat[121:0] & ~low_mask_i & ~low_inhibit_i);
  end

  // Last valid vector memory
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ever_pending <= 1'b0;
      last_vector  <= VEC_TRAP;
    end else begin
      if (next_pending || |reset_req_i || core_req_i.illegal_op || core_req_i.trap_or_debug) begin
        ever_pending <= 1'b1;
        last_vector  <= next_vector;
      end
    end
  end

  // Vector output on fetch
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      vector_o <= '0;
    end else if (vector_fetch_i) begin
      vector_o.valid   <= next_valid;
      vector_o.address <= next_vector;
    end else begin
      vector_o.valid <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pending_o <= 1'b0;
    end else begin
      pending_o <= next_pending;
    end
  end

  // Wake path; live inputs only, registered for the output
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= ~nmi_pin_req_n_i | (|live_flat[121:0] & ~low_mask_i);
    end
  end

  // APB decode in the setup phase
  wire logic       apb_setup    = psel_i & ~penable_i;
  wire logic       hit_control  = (paddr_i == ADDR_TEST_CONTROL);
  wire logic       hit_force    = (paddr_i == ADDR_TEST_FORCE);
  wire logic       hit_promote  = (paddr_i == ADDR_PROMOTE_SEL);
  wire logic       hit_status   = (paddr_i == ADDR_STATUS);
  wire logic       hit_writable = hit_control | hit_force | hit_promote;
  logic [31:0]     next_prdata;
  logic            next_pslverr;

  // Read data and error chosen at setup, shown in the access phase
  always_comb begin
    next_prdata  = '0;
    next_pslverr = 1'b0;
    if (apb_setup && !pwrite_i) begin
      if (hit_control) begin
        next_prdata = {27'h0, test_write_enable, test_select};
      end else if (hit_force) begin
        if (special_mode_i && slot_ok) begin
          next_prdata = {24'h0, slot_bits(decode_flat, test_select)
                                & slot_mask(test_select)};
        end
      end else if (hit_promote) begin
        next_prdata = {24'h0, promote_sel};
      end else if (hit_status) begin
        next_prdata = {14'h0, ever_pending, next_pending, next_vector};
      end else begin
        next_pslverr = 1'b1;
      end
    end else if (apb_setup && pwrite_i) begin
      if (!hit_writable) begin
        next_pslverr = 1'b1;
      end
    end
  end

  // Answer flops: one-cycle pulse, no wait states
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= apb_setup;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pslverr_o <= 1'b0;
    end else begin
      pslverr_o <= next_pslverr;
    end
  end

  // Read data is zero outside the answer cycle
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= '0;
    end else begin
      prdata_o <= next_prdata;
    end
  end

endmodule : ipvu_top
`default_nettype wire

// >>> test/ipvu_monitor.sv
// Checker for bus, vector and wake behaviour of the interrupt vector unit
`default_nettype none
module ipvu_monitor
  import ipvu_pkg::*;
(
  input wire logic            clock_i, rst_i, psel_i, penable_i, pwrite_i,
  input wire logic [9:0]      paddr_i,
  input wire logic [31:0]     prdata_o,
  input wire logic            pready_o, pslverr_o, special_mode_i, nmi_pin_req_n_i,
  input wire logic            vector_fetch_i, wake_o,
  input wire ipvu_core_req_t  core_req_i,
  input wire ipvu_reset_req_t reset_req_i,
  input wire ipvu_vector_t    vector_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_ready_access: assert property (psel_i && !penable_i |=> pready_o)
    else $error("ready missing in access phase");
  a_ready_only: assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside a transfer");
  a_error_pair: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_rdata_quiet: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data outside answer");
  a_fetch_answer: assert property (1'b1 |=> vector_o.valid == $past(vector_fetch_i))
    else $error("vector valid not one cycle after fetch");
  a_address_hold: assert property (!vector_fetch_i |=> $stable(vector_o.address))
    else $error("vector address moved without fetch");
  a_reset_first: assert property (vector_fetch_i && reset_req_i.system
    |=> vector_o.address == VEC_SYS_RESET)
    else $error("system reset vector not chosen");
  a_illegal_vector: assert property (vector_fetch_i && core_req_i.illegal_op && !(|reset_req_i)
    |=> vector_o.address == VEC_ILLEGAL)
    else $error("illegal opcode vector not chosen");
  a_pin_wake: assert property (!nmi_pin_req_n_i ##1 !nmi_pin_req_n_i |-> wake_o)
    else $error("no wake on nonmaskable pin");
  a_normal_read: assert property (psel_i && !penable_i && !pwrite_i && !special_mode_i
    && paddr_i == ADDR_TEST_FORCE |=> prdata_o == 32'h0)
    else $error("force register readable in normal mode");
  c_reset_fetch: cover property (vector_fetch_i && reset_req_i.system);
  c_force_read: cover property (psel_i && special_mode_i && paddr_i == ADDR_TEST_FORCE);
  c_pin_wake: cover property (!nmi_pin_req_n_i ##1 wake_o);
endmodule : ipvu_monitor
bind ipvu_top ipvu_monitor ipvu_monitor_inst (.clock_i(clock_i), .rst_i(rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .special_mode_i(special_mode_i), .nmi_pin_req_n_i(nmi_pin_req_n_i),
  .vector_fetch_i(vector_fetch_i), .wake_o(wake_o), .core_req_i(core_req_i),
  .reset_req_i(reset_req_i), .vector_o(vector_o));
`default_nettype wire

// >>> test/ipvu_source_model.sv
// Peripheral request sources: level requests held until dropped
`default_nettype none
module ipvu_source_model #(
  parameter int NUM_SOURCES = 122
) (
  input  wire logic                   clock_i,
  input  wire logic                   rst_i,
  input  wire logic                   raise_i,
  input  wire logic                   drop_i,
  input  wire logic [6:0]             index_i,
  output logic      [NUM_SOURCES-1:0] source_req_o
);
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      source_req_o <= '0;
    end else if (drop_i) begin
      source_req_o <= '0;
    end else if (raise_i) begin
      source_req_o <= source_req_o | (NUM_SOURCES'(1) << index_i);
    end
  end
endmodule : ipvu_source_model
`default_nettype wire

// >>> test/ipvu_tb_top.sv
// Self-checking bench for the interrupt priority vector unit
`default_nettype none
module ipvu_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ipvu_pkg::*;
  localparam int NS = 122;
  logic clock_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0, vf = 0, raise = 0, drop = 0;
  logic spec = 0, lmask = 1, hmask = 1, linh = 0, hinh = 0, lpin_n = 1, npin_n = 1;
  logic pready_o, pslverr_o, pending_o, wake_o;
  logic [9:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata_o;
  logic [6:0] idx = '0;
  logic [NS-1:0] src;
  ipvu_core_req_t creq = '0;
  ipvu_reset_req_t rreq = '0;
  ipvu_vector_t vector_o;
  logic [32:0] q_rd[$];
  logic [15:0] q_vec[$];
  int n_fail = 0, compares = 0, seed = 55838;
  always #2.5 clock_i = ~clock_i;
  ipvu_source_model #(.NUM_SOURCES(NS)) ipvu_source_model_inst (.clock_i(clock_i),
    .rst_i(rst_i), .raise_i(raise), .drop_i(drop), .index_i(idx), .source_req_o(src));
  ipvu_top #(.NUM_SOURCES(NS)) ipvu_top_inst (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .special_mode_i(spec),
    .low_mask_i(lmask), .high_mask_i(hmask), .low_inhibit_i(linh), .high_inhibit_i(hinh),
    .source_req_i(src), .low_pin_req_n_i(lpin_n), .nmi_pin_req_n_i(npin_n), .core_req_i(creq),
    .reset_req_i(rreq), .vector_fetch_i(vf), .vector_o(vector_o), .pending_o(pending_o),
    .wake_o(wake_o));
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report
  task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clock_i);
  endtask : apb
  task automatic rd(input logic [9:0] a, input logic [32:0] exp);
    q_rd.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic fetch(input logic [15:0] exp);
    q_vec.push_back(exp);
    repeat (3) @(posedge clock_i);
    vf <= 1'b1;
    @(posedge clock_i);
    vf <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask : fetch
  // Results arrive here and are matched against the oldest note
  always @(posedge clock_i) begin
    if (pready_o === 1'b1 && !pwrite) begin
      check("read", {pslverr_o, prdata_o}, q_rd.size() ? q_rd.pop_front() : 33'h1FFFFFFFF);
    end
    if (vector_o.valid === 1'b1) begin
      check("vector", {17'h0, vector_o.address},
        q_vec.size() ? {17'h0, q_vec.pop_front()} : 33'h1FFFFFFFF);
    end
  end
  initial begin
    #20000;
    n_fail++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    fetch(VEC_TRAP);
    rd(ADDR_TEST_CONTROL, 33'h0F);
    rd(10'h3F0, 33'h100000000);
    rd(ADDR_TEST_FORCE, 33'h0);
    apb(1'b1, ADDR_TEST_CONTROL, 32'h1F);
    rd(ADDR_TEST_CONTROL, 33'h0F);
    // Requests added lowest first, each fetch sees the newest on top
    for (int i = 4; i >= 0; i--) begin
      if (i < 3) rreq[2-i] <= 1'b1;
      else creq[6-i] <= 1'b1;
      fetch(VEC_SYS_RESET - 16'(2 * i));
    end
    rreq <= '0; creq <= '0; hmask <= 1'b0; npin_n <= 1'b0;
    fetch(VEC_NMI_PIN);
    hmask <= 1'b1;
    repeat (3) @(posedge clock_i);
    check("wake", {32'h0, wake_o}, 33'h1);
    npin_n <= 1'b1; lmask <= 1'b0; lpin_n <= 1'b0;
    fetch(VEC_LOW_PIN);
    check("pending", {32'h0, pending_o}, 33'h1);
    linh <= 1'b1;
    repeat (3) @(posedge clock_i);
    check("pending", {32'h0, pending_o}, 33'h0);
    linh <= 1'b0; lpin_n <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      int j;
      j = $unsigned($random(seed)) % (NS - 1);
      idx <= 7'(j); raise <= 1'b1;
      @(posedge clock_i);
      raise <= 1'b0;
      fetch(16'hFFF0 - 16'(2 * (NS - 2 - j)));
      check("wake", {32'h0, wake_o}, 33'h1);
      drop <= 1'b1;
      @(posedge clock_i);
      drop <= 1'b0;
    end
    lmask <= 1'b1;
    apb(1'b1, ADDR_PROMOTE_SEL, 32'hE0);
    rd(ADDR_PROMOTE_SEL, 33'hE0);
    idx <= 7'd112; raise <= 1'b1;
    @(posedge clock_i);
    idx <= 7'd120;
    @(posedge clock_i);
    raise <= 1'b0; lmask <= 1'b0;
    fetch(16'hFFE0);
    rd(ADDR_STATUS, 33'h0003FFE0);
    drop <= 1'b1;
    @(posedge clock_i);
    drop <= 1'b0;
    spec <= 1'b1; lmask <= 1'b1; lpin_n <= 1'b0;
    @(posedge clock_i);
    rd(ADDR_TEST_FORCE, 33'h02);
    apb(1'b1, ADDR_TEST_FORCE, 32'h01);
    rd(ADDR_TEST_FORCE, 33'h02);
    apb(1'b1, ADDR_TEST_CONTROL, 32'h1F);
    rd(ADDR_TEST_CONTROL, 33'h1F);
    rd(ADDR_TEST_FORCE, 33'h02);
    apb(1'b1, ADDR_TEST_FORCE, 32'hFF);
    rd(ADDR_TEST_FORCE, 33'h07);
    apb(1'b1, ADDR_TEST_FORCE, 32'h01);
    rd(ADDR_TEST_FORCE, 33'h01);
    lmask <= 1'b0;
    fetch(16'hFFF0);
    apb(1'b1, ADDR_TEST_CONTROL, 32'h17);
    rd(ADDR_TEST_CONTROL, 33'h17);
    spec <= 1'b0;
    rd(ADDR_TEST_FORCE, 33'h0);
    final_report();
  end
endmodule : ipvu_tb_top
`default_nettype wire
